// ---- isf_status_flags.sv ----
// Purpose: Status flags, stall and stop drive of the serial bus master
// Assumes: Clock line toggled by the baud logic, seen here as a pin
// Notes: Register port is byte wide; read data stand one cycle later
`timescale 1ns/1ps
module isf_status_flags
    import isf_pkg::*;
(
    input wire logic clk_i,          // System clock, 20 MHz
    input wire logic arst_n_i,       // Async reset, active low
    input wire logic [7:0] addr_i,   // Register address
    input wire logic [7:0] wdata_i,  // Register write data
    input wire logic wr_i,           // Write strobe
    input wire logic rd_i,           // Read strobe
    input wire logic scl_i,          // Clock line level
    input wire logic sda_i,          // Data line level
    output logic [7:0] rdata_o,      // Read data, cycle after strobe
    output logic irq_o,              // Level interrupt
    output logic scl_o,              // Clock line drive value
    output logic scl_oe_o,           // Clock line pulled low
    output logic sda_o,              // Data line drive value
    output logic sda_oe_o            // Data line pulled low
);
    // Synchronised pins and delayed copies
    logic [1:0] pin_q;
    logic scl_s;
    logic sda_s;
    logic scl_d_reg;
    logic sda_d_reg;
    // Bus events
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic in_frame;
    logic ack_sample;
    logic ack_start;
    logic byte_done;
    logic nack_evt;
    logic stall_hit;
    // Register decode
    logic wr_ctrl;
    logic wr_data;
    logic wr_istat;
    logic wr_imask;
    logic rd_istat;
    logic start_set;
    logic stop_set;
    logic [7:0] status_w;
    logic [7:0] rsel_w;
    logic tas_w;
    logic dss_w;
    // State
    isf_phase_t phase_reg, phase_next;
    logic [3:0] cnt_reg, cnt_next;
    logic en_reg;
    logic start_req_reg, start_req_next;
    logic stop_req_reg, stop_req_next;
    logic [7:0] data_reg;
    logic transmit_buffer_empty_reg, transmit_buffer_empty_next;
    logic ack_reg, ack_next;
    logic nack_reg, nack_next;
    logic ten_reg, ten_next;
    logic dir_reg, dir_next;
    logic stall_reg, stall_next;
    logic stop_drv_reg, stop_drv_next;
    logic [IRQ_W-1:0] istat_reg, istat_next;
    logic [IRQ_W-1:0] imask_reg;
    logic [IRQ_W-1:0] irq_evt;
    logic irq_reg;
    logic [7:0] rdata_reg;
    logic pin_lo_reg;

    // Pin synchroniser
    isf_sync #(.W(2)) u_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .d_i({scl_i, sda_i}),
        .q_o(pin_q)
    );
    assign scl_s = pin_q[1];
    assign sda_s = pin_q[0];

    // Edge and condition detection on synchronised lines
    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    assign in_frame = en_reg & (phase_reg != PH_IDLE);
    // Ninth rising edge samples the acknowledge, never while stalled
    assign ack_sample = in_frame & scl_rise & ~stall_reg
        & (cnt_reg == DATA_BITS);
    assign ack_start = in_frame & scl_fall & (cnt_reg == DATA_BITS);
    assign byte_done = in_frame & scl_fall & (cnt_reg == FRAME_BITS);
    assign nack_evt = ack_sample & sda_s;
    // Write with nothing queued and no start or stop pending
    assign stall_hit = ack_start & ~dir_reg & transmit_buffer_empty_reg
        & ~start_req_reg & ~stop_req_reg;

    // Register decode
    assign wr_ctrl = wr_i & (addr_i == OFF_CTRL);
    assign wr_data = wr_i & (addr_i == OFF_DATA);
    assign wr_istat = wr_i & (addr_i == OFF_ISTAT);
    assign wr_imask = wr_i & (addr_i == OFF_IMASK);
    assign rd_istat = rd_i & (addr_i == OFF_ISTAT);
    // Start and stop can only be set by software; cleared once sent on the bus or on disable
    assign start_set = wr_ctrl & wdata_i[CTRL_START];
    assign stop_set = wr_ctrl & wdata_i[CTRL_STOP];

    // Phase flags decoded from bus phase and bit count
    assign tas_w = (phase_reg == PH_ADDR) & (cnt_reg < DATA_BITS);
    assign dss_w = (phase_reg == PH_DATA) & (cnt_reg < DATA_BITS);
    assign status_w = {transmit_buffer_empty_reg, 1'b0, ack_reg, ten_reg, dir_reg,
        tas_w, dss_w, nack_reg};
    // Read mux, unmapped and write-only offsets read zero
    assign rsel_w =
        (addr_i == OFF_CTRL) ? {en_reg, start_req_reg, stop_req_reg,
            5'h00} :
        (addr_i == OFF_STATUS) ? status_w :
        (addr_i == OFF_ISTAT) ? {5'h00, istat_reg} :
        (addr_i == OFF_IMASK) ? {5'h00, imask_reg} : 8'h00;

    // Bus phase tracking; disable drops to idle
    always_comb
    begin
        phase_next = phase_reg;
        if (!en_reg)
            phase_next = PH_IDLE;
        else if (start_cond)
            phase_next = PH_ADDR;
        else if (stop_cond)
            phase_next = PH_IDLE;
        else if (byte_done && phase_reg == PH_ADDR)
            // Ten-bit header is followed by a second address byte
            phase_next = ten_reg ? PH_ADDR : PH_DATA;
    end

    // Bit counter within a frame
    always_comb
    begin
        cnt_next = cnt_reg;
        if (!en_reg || start_cond || byte_done)
            cnt_next = 4'h0;
        else if (in_frame && scl_rise)
            cnt_next = cnt_reg + 4'h1;
    end

    // Acknowledge flag: set on ack, cleared on nack or disable
    always_comb
    begin
        ack_next = ack_reg;
        if (!en_reg)
            ack_next = 1'b0;
        else if (ack_sample)
            ack_next = ~sda_s;
    end

    // Not-acknowledge flag; hardware set wins over all clears but disable
    always_comb
    begin
        nack_next = nack_reg;
        if (!en_reg)
            nack_next = 1'b0;
        else if (nack_evt && !start_req_reg && !stop_req_reg)
            nack_next = 1'b1;
        else if (start_set || stop_set)
            nack_next = 1'b0;
        else if (stop_cond)
            nack_next = 1'b0;
    end

    // Start and stop requests, cleared once sent or on disable
    always_comb
    begin
        start_req_next = start_req_reg;
        stop_req_next = stop_req_reg;
        if (!en_reg)
        begin
            start_req_next = 1'b0;
            stop_req_next = 1'b0;
        end
        else
        begin
            if (start_set)
                start_req_next = 1'b1;
            else if (start_cond)
                start_req_next = 1'b0;
            if (stop_set)
                stop_req_next = 1'b1;
            else if (stop_cond)
                stop_req_next = 1'b0;
        end
    end

    // Ten-bit and direction flags, captured when start is set
    always_comb
    begin
        ten_next = ten_reg;
        dir_next = dir_reg;
        if (!en_reg)
        begin
            ten_next = 1'b0;
            dir_next = 1'b0;
        end
        else if (start_set)
        begin
            ten_next = (data_reg[7:3] == TEN_HDR);
            dir_next = data_reg[0];
        end
        else if (byte_done && phase_reg == PH_ADDR)
            ten_next = 1'b0;
    end

    // Transmit buffer empty; reload by the shifter sets it again
    always_comb
    begin
        transmit_buffer_empty_next = transmit_buffer_empty_reg;
        if (!en_reg)
            transmit_buffer_empty_next = TRANSMIT_BUFFER_EMPTY_RST;
        else if (start_cond || byte_done)
            transmit_buffer_empty_next = 1'b1;
        else if (wr_data)
            transmit_buffer_empty_next = 1'b0;
    end

    // Clock stretch and stop drive
    always_comb
    begin
        stall_next = stall_reg;
        stop_drv_next = stop_drv_reg;
        if (!en_reg)
        begin
            stall_next = 1'b0;
            stop_drv_next = 1'b0;
        end
        else
        begin
            if (stall_hit)
                stall_next = 1'b1;
            else if (stall_reg && !transmit_buffer_empty_reg)
                stall_next = 1'b0;
            // Hold data low over clock low, release with clock high
            if (byte_done && stop_req_reg)
                stop_drv_next = 1'b1;
            else if (stop_drv_reg && scl_s)
                stop_drv_next = 1'b0;
        end
    end

    // Interrupt status: read clears, a new event wins
    assign irq_evt = {byte_done, stop_cond & en_reg,
        nack_next & ~nack_reg};
    assign istat_next = (istat_reg & ~{IRQ_W{rd_istat}}) | irq_evt;

    // Pin history
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // Software written registers; status offset has no write path
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            en_reg <= 1'b0;
            data_reg <= DATA_RST;
            imask_reg <= IMASK_RST;
        end
        else
        begin
            if (wr_ctrl)
                en_reg <= wdata_i[CTRL_EN];
            if (wr_data)
                data_reg <= wdata_i;
            if (wr_imask)
                imask_reg <= wdata_i[IRQ_W-1:0];
        end
    end

    // Flag and phase state
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            phase_reg <= PH_IDLE;
            cnt_reg <= 4'h0;
            start_req_reg <= 1'b0;
            stop_req_reg <= 1'b0;
            transmit_buffer_empty_reg <= TRANSMIT_BUFFER_EMPTY_RST;
            ack_reg <= 1'b0;
            nack_reg <= 1'b0;
            ten_reg <= 1'b0;
            dir_reg <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            cnt_reg <= cnt_next;
            start_req_reg <= start_req_next;
            stop_req_reg <= stop_req_next;
            transmit_buffer_empty_reg <= transmit_buffer_empty_next;
            ack_reg <= ack_next;
            nack_reg <= nack_next;
            ten_reg <= ten_next;
            dir_reg <= dir_next;
        end
    end

    // Output drivers and interrupt
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            stall_reg <= 1'b0;
            stop_drv_reg <= 1'b0;
            istat_reg <= '0;
            irq_reg <= 1'b0;
            rdata_reg <= 8'h00;
            pin_lo_reg <= 1'b0;
        end
        else
        begin
            stall_reg <= stall_next;
            stop_drv_reg <= stop_drv_next;
            istat_reg <= istat_next;
            irq_reg <= |(istat_next & imask_reg);
            rdata_reg <= rd_i ? rsel_w : 8'h00;
            pin_lo_reg <= 1'b0;
        end
    end

    assign rdata_o = rdata_reg;
    assign irq_o = irq_reg;
    assign scl_o = pin_lo_reg;
    assign sda_o = pin_lo_reg;
    assign scl_oe_o = stall_reg;
    assign sda_oe_o = stop_drv_reg;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_stall_release;
        stall_reg && en_reg ##1 !transmit_buffer_empty_reg;
    endsequence

    a_ack_set_seen: assert property (
        ack_sample && !sda_s |=> ack_reg)
        else $error("ack flag not set after acknowledge");
    a_ack_clr_off: assert property (
        !en_reg |=> !ack_reg && !nack_reg)
        else $error("flags not cleared while disabled");
    a_ack_kept_read: assert property (
        en_reg && !ack_sample && (rd_i || start_cond) |=> $stable(ack_reg))
        else $error("ack flag changed without acknowledge");
    a_stall_entry: assert property (
        en_reg && stall_hit && !wr_i |=> scl_oe_o [*2])
        else $error("clock line not stretched at ack cycle");
    a_stall_release: assert property (
        s_stall_release |=> !scl_oe_o)
        else $error("stretch not released after data write");
    a_stall_ack_hold: assert property (
        stall_reg && en_reg |=> $stable(ack_reg))
        else $error("ack flag moved during stretch");
    a_ten_detect: assert property (
        en_reg && start_set && data_reg[7:3] == TEN_HDR |=> ten_reg)
        else $error("ten-bit flag missed");
    a_ten_clear: assert property (
        byte_done && phase_reg == PH_ADDR && !start_set |=> !ten_reg)
        else $error("ten-bit flag kept after first address");
    a_dir_copy: assert property (
        en_reg && start_set |=> dir_reg == $past(data_reg[0]))
        else $error("direction flag wrong");
    a_addr_phase: assert property (
        en_reg && start_cond |=> tas_w && !dss_w)
        else $error("address phase flag not raised");
    a_nack_set: assert property (
        nack_evt && !nack_reg && !start_req_reg && !stop_req_reg
        |=> nack_reg ##1 istat_reg[IRQ_NACK] || $past(rd_istat))
        else $error("nack flag or event missing");
    a_nack_sticky: assert property (
        nack_reg && en_reg && !start_set && !stop_set && !stop_cond
        |=> nack_reg)
        else $error("nack flag cleared without request");
    a_stop_clears: assert property (
        en_reg && stop_cond && !stop_set && !start_set && !nack_evt
        |=> !stop_req_reg && !nack_reg)
        else $error("stop did not clear request and flag");
    a_disable_idle: assert property (
        !en_reg |=> phase_reg == PH_IDLE && !start_req_reg && !scl_oe_o)
        else $error("disabled controller still active");
    a_status_wr: assert property (
        wr_i && addr_i == OFF_STATUS && en_reg |=> $stable(dir_reg))
        else $error("status write changed a flag");
endmodule

// ---- isf_pkg.sv ----
// Purpose: Constants for the serial bus status flag block
// Assumes: 8-bit register port, one byte per register offset
// Notes: Status bits follow the flag layout of the status register
// How it works
// - Observed acknowledge sets the acknowledge flag
// - Disable or not-acknowledge clears acknowledge flag
// - Acknowledge flag survives new start and reads
// - Write with empty buffer stalls at acknowledge
// - Acknowledge flag frozen until stall releases
// - Start request with header sets ten-bit flag
// - First address byte sent clears ten-bit flag
// - Start request copies shift LSB to direction
// - Address flag high while address bits shift
// - Data flag high while data bits shift
// - Not-acknowledge without start/stop sets not-acknowledge flag
// - Start or stop request, stop condition or disable clears it
// - Stop request drives stop, clears stop, flag
// - Controller disable stops bus, clears flags
package isf_pkg;
    // Register offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DATA = 8'h01;
    localparam logic [7:0] OFF_STATUS = 8'h02;
    localparam logic [7:0] OFF_ISTAT = 8'h03;
    localparam logic [7:0] OFF_IMASK = 8'h04;
    // Control register fields
    localparam int CTRL_EN = 7;
    localparam int CTRL_START = 6;
    localparam int CTRL_STOP = 5;
    // Status register fields
    localparam int ST_TRANSMIT_BUFFER_EMPTY = 7;
    localparam int ST_RDRF = 6;
    localparam int ST_ACK = 5;
    localparam int ST_TEN = 4;
    localparam int ST_RD = 3;
    localparam int ST_TAS = 2;
    localparam int ST_DSS = 1;
    localparam int ST_NACK = 0;
    // Interrupt status fields
    localparam int IRQ_W = 3;
    localparam int IRQ_NACK = 0;
    localparam int IRQ_STOP = 1;
    localparam int IRQ_BYTE = 2;
    // Reset values
    localparam logic TRANSMIT_BUFFER_EMPTY_RST = 1'b1;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [IRQ_W-1:0] IMASK_RST = 3'h0;
    // Ten-bit address header in the upper five bits
    localparam logic [4:0] TEN_HDR = 5'h1e;
    // Bit counts within one byte frame
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] FRAME_BITS = 4'h9;
    // Bus phase, Gray coded along idle, address, data
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ADDR = 2'b01,
        PH_DATA = 2'b11
    } isf_phase_t;
endpackage

// ---- isf_sync.sv ----
// Purpose: Two-stage synchroniser for bus pin inputs
// Assumes: Inputs are asynchronous to clk_i
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module isf_sync #(
    parameter int W = 2
) (
    input wire logic clk_i,          // System clock
    input wire logic arst_n_i,       // Async reset, active low
    input wire logic [W-1:0] d_i,    // Raw pin levels
    output logic [W-1:0] q_o         // Synchronised levels
);
    logic [W-1:0] meta_reg; // First stage
    logic [W-1:0] sync_reg; // Second stage

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            // One two-flop chain per pin
            always_ff @(posedge clk_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                begin
                    meta_reg[g] <= 1'b1;
                    sync_reg[g] <= 1'b1;
                end
                else
                begin
                    meta_reg[g] <= d_i[g];
                    sync_reg[g] <= meta_reg[g];
                end
            end
        end
    endgenerate

    assign q_o = sync_reg;
endmodule

// ---- isf_bus_model.sv ----
// Purpose: Far side of the two-wire bus, seen from the status flags
// Assumes: Both wires pulled up; the design only ever pulls them low
// Notes: Link clock runs only inside frames, 400 ns period
`timescale 1ns/1ps
module isf_bus_model (
    input wire logic scl_oe_i, // Design pulls clock low
    input wire logic sda_oe_i, // Design pulls data low
    output logic scl_o,        // Clock wire level
    output logic sda_o         // Data wire level
);
    logic scl_drv = 1'b1; // Own clock drive, released high
    logic sda_drv = 1'b1; // Own data drive, released high
    int n_stuck = 0;      // Stretch waits that ran out

    // Wired-and of both parties over the pull-ups
    assign scl_o = scl_drv & ~scl_oe_i;
    assign sda_o = sda_drv & ~sda_oe_i;

    // Data falls while clock is high
    task automatic start_cond();
        sda_drv = 1'b0;
        #200;
        scl_drv = 1'b0;
        #200;
    endtask

    // One clock pulse; a held-low clock is waited out, bounded
    task automatic pulse();
        int i;
        #100;
        scl_drv = 1'b1;
        i = 0;
        while (scl_o !== 1'b1 && i < 4000)
        begin
            #50;
            i++;
        end
        if (i == 4000)
            n_stuck++;
        #200;
        scl_drv = 1'b0;
        #100;
    endtask

    // Eight bits, most significant first, changed while clock low
    task automatic bits8(input logic [7:0] d);
        for (int b = 7; b >= 0; b--)
        begin
            sda_drv = d[b];
            pulse();
        end
        sda_drv = 1'b1;
    endtask

    // Ninth bit: low for acknowledge, released for refusal
    task automatic ack_cycle(input logic ack);
        sda_drv = ~ack;
        pulse();
        sda_drv = 1'b1;
    endtask

    // Clock released high; design then lets data rise
    task automatic stop_cond();
        #100;
        scl_drv = 1'b1;
        #400;
    endtask
endmodule

// ---- isf_status_flags_test.sv ----
// Purpose: Self-checking bench for the status flag block
// Assumes: Far side given by the bus model, 20 MHz system clock
// Notes: One ten-bit write transfer, then a second start and disable
`timescale 1ns/1ps
module isf_status_flags_test;
    import isf_pkg::*;
    logic clk_i = 1'b0;        // System clock
    logic arst_n_i = 1'b0;     // Reset, active low
    logic [7:0] addr_i;
    logic [7:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic scl_i;               // Clock wire level
    logic sda_i;               // Data wire level
    logic [7:0] rdata_o;
    logic irq_o;
    logic scl_o;               // Clock drive value
    logic sda_o;               // Data drive value
    logic scl_oe_o;
    logic sda_oe_o;
    logic [7:0] rv;            // Last read value
    int n_mismatch = 0;
    int samples_checked = 0;

    isf_status_flags u_isf_status_flags (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .scl_i(scl_i),
        .sda_i(sda_i), .rdata_o(rdata_o), .irq_o(irq_o), .scl_o(scl_o),
        .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o));

    isf_bus_model bus_far (
        .scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o),
        .scl_o(scl_i), .sda_o(sda_i));

    // 50 ns clock
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // One-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic chk_byte(input string nm, input logic [7:0] e,
                            input logic [7:0] g, input logic [7:0] m);
        samples_checked++;
        if ((g & m) !== (e & m))
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e & m, g & m);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask

    // Register read compared under a mask
    task automatic chk_reg(input string nm, input logic [7:0] a,
                           input logic [7:0] e, input logic [7:0] m);
        logic [7:0] d;
        rd_reg(a, d);
        chk_byte(nm, e, d, m);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        addr_i <= 8'h00;
        wdata_i <= 8'h00;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1'b1;
        // Reset values, refused writes, unmapped read
        chk_reg("status", OFF_STATUS, 8'h80, 8'hff);
        chk_reg("ctrl", OFF_CTRL, 8'h00, 8'hff);
        chk_reg("unmapped", 8'h07, 8'h00, 8'hff);
        wr_reg(OFF_STATUS, 8'h7f);
        chk_reg("status", OFF_STATUS, 8'h80, 8'hff);
        wr_reg(OFF_IMASK, 8'h01);
        chk_reg("imask", OFF_IMASK, 8'h01, 8'h07);
        // Enable first; a disabled block drops start and leaves the buffer flagged empty
        wr_reg(OFF_CTRL, 8'h80);
        chk_reg("ctrl", OFF_CTRL, 8'h80, 8'he0);
        // Ten-bit header, write direction
        wr_reg(OFF_DATA, 8'hf0);
        wr_reg(OFF_CTRL, 8'hc0);
        rd_reg(OFF_STATUS, rv);
        chk_bit("ten", 1'b1, rv[ST_TEN]);
        chk_bit("dir", 1'b0, rv[ST_RD]);
        bus_far.start_cond();
        idle(10);
        rd_reg(OFF_STATUS, rv);
        chk_bit("tas", 1'b1, rv[ST_TAS]);
        chk_bit("dss", 1'b0, rv[ST_DSS]);
        chk_reg("ctrl", OFF_CTRL, 8'h80, 8'he0);
        // First address byte, data already waiting
        wr_reg(OFF_DATA, 8'h5a);
        bus_far.bits8(8'hf0);
        idle(10);
        chk_bit("stretch", 1'b0, scl_oe_o);
        bus_far.ack_cycle(1'b1);
        idle(10);
        rd_reg(OFF_STATUS, rv);
        chk_bit("ack", 1'b1, rv[ST_ACK]);
        chk_bit("ten", 1'b0, rv[ST_TEN]);
        chk_bit("tas", 1'b1, rv[ST_TAS]);
        // Second address byte, then data phase
        wr_reg(OFF_DATA, 8'h33);
        bus_far.bits8(8'h5a);
        bus_far.ack_cycle(1'b1);
        idle(10);
        rd_reg(OFF_STATUS, rv);
        chk_bit("tas", 1'b0, rv[ST_TAS]);
        chk_bit("dss", 1'b1, rv[ST_DSS]);
        // Data byte with empty buffer: stall, then refusal
        bus_far.bits8(8'h33);
        idle(10);
        chk_bit("stretch", 1'b1, scl_oe_o);
        rd_reg(OFF_STATUS, rv);
        chk_bit("ack held", 1'b1, rv[ST_ACK]);
        wr_reg(OFF_DATA, 8'h44);
        idle(4);
        chk_bit("stretch", 1'b0, scl_oe_o);
        bus_far.ack_cycle(1'b0);
        idle(10);
        rd_reg(OFF_STATUS, rv);
        chk_bit("ack", 1'b0, rv[ST_ACK]);
        chk_bit("nack", 1'b1, rv[ST_NACK]);
        chk_bit("irq", 1'b1, irq_o);
        chk_reg("istat", OFF_ISTAT, 8'h05, 8'h07);
        idle(2);
        chk_bit("irq", 1'b0, irq_o);
        chk_reg("nack", OFF_STATUS, 8'h01, 8'h01);
        wr_reg(OFF_CTRL, 8'ha0);
        chk_reg("nack", OFF_STATUS, 8'h00, 8'h01);
        // Last byte with stop pending: no stall, stop driven
        bus_far.bits8(8'h44);
        idle(10);
        chk_bit("stretch", 1'b0, scl_oe_o);
        bus_far.ack_cycle(1'b1);
        idle(10);
        chk_bit("stop drive", 1'b1, sda_oe_o);
        chk_bit("data drive", 1'b0, sda_o);
        chk_bit("clock drive", 1'b0, scl_o);
        bus_far.stop_cond();
        idle(10);
        chk_bit("stop drive", 1'b0, sda_oe_o);
        chk_bit("data line", 1'b1, sda_i);
        chk_reg("ctrl", OFF_CTRL, 8'h80, 8'he0);
        chk_reg("istat", OFF_ISTAT, 8'h02, 8'h02);
        chk_reg("status", OFF_STATUS, 8'h20, 8'h27);
        // New start keeps ack; read direction; then disable
        wr_reg(OFF_DATA, 8'h11);
        wr_reg(OFF_CTRL, 8'hc0);
        rd_reg(OFF_STATUS, rv);
        chk_bit("ack", 1'b1, rv[ST_ACK]);
        chk_bit("ten", 1'b0, rv[ST_TEN]);
        chk_bit("dir", 1'b1, rv[ST_RD]);
        wr_reg(OFF_STATUS, 8'h00);
        chk_reg("status", OFF_STATUS, 8'h28, 8'h3f);
        wr_reg(OFF_CTRL, 8'h00);
        chk_reg("status", OFF_STATUS, 8'h00, 8'h3f);
        chk_reg("ctrl", OFF_CTRL, 8'h00, 8'he0);
        chk_byte("stretch waits", 8'h00, 8'(bus_far.n_stuck), 8'hff);
        print_verdict();
    end
endmodule
